// File: rtl/cdpc_clock_ctrl.v
// Clock rate selection and PLL control registers
module cdpc_clock_ctrl (
  input wire mclk,
  input wire sys_rst,
  input wire [7:0] sfrAddr,
  input wire [7:0] sfrWdata,
  input wire sfrWe,
  input wire sfrRe,
  input wire pllLockRaw,
  output reg [7:0] sfrRdata,
  output reg cpuTick,
  output reg watchdogTick,
  output reg counterArrayTick,
  output reg uartTick,
  output reg timerCTick,
  output reg timerBTick,
  output reg timerATick,
  output reg spiTick,
  output reg pllEnable,
  output reg externalUsbClockSel,
  output reg oscEnable,
  output reg [3:0] pllRefDivider,
  output reg [3:0] pllInputDivider,
  output reg pllLockFlag
);
`include "cdpc_regs.vh"
  reg [7:0] rateA_q;
  reg [7:0] rateB_q;
  reg [7:0] pllCtl_q;
  reg [7:0] pll_divider_q;
  reg lockS1_q;
  reg lockS2_q;
  reg lockS3_q;
  reg lock_q;
  reg [3:0] cpuCnt_q;
  wire coreDbl = rateA_q[`CDPC_BIT_CORE_DBL];
  wire [6:0] perSel;
  wire [6:0] perTick;
  wire [3:0] cpuLast;
  wire [7:0] pllCtlRead;

  function [7:0] regRead;
    input [7:0] addr;
    input [7:0] a;
    input [7:0] b;
    input [7:0] c;
    input [7:0] d;
    begin
      case (addr)
        `CDPC_ADDR_RATE_A: regRead = a;
        `CDPC_ADDR_RATE_B: regRead = b;
        `CDPC_ADDR_PLL_CTL: regRead = c;
        `CDPC_ADDR_PLL_DIV: regRead = d;
        default: regRead = 8'h00;
      endcase
    end
  endfunction

  always @(posedge mclk) begin
    if (sys_rst) begin
      rateA_q <= `CDPC_RST_VAL;
      rateB_q <= `CDPC_RST_VAL;
      pllCtl_q <= `CDPC_RST_VAL;
      pll_divider_q <= `CDPC_RST_VAL;
    end else if (sfrWe) begin
      case (sfrAddr)
        `CDPC_ADDR_RATE_A: rateA_q <= sfrWdata & `CDPC_RATE_A_MASK;
        `CDPC_ADDR_RATE_B: rateB_q <= sfrWdata & `CDPC_RATE_B_MASK;
        `CDPC_ADDR_PLL_CTL: pllCtl_q <= sfrWdata & `CDPC_PLL_CTL_MASK;
        `CDPC_ADDR_PLL_DIV: pll_divider_q <= sfrWdata;
        default: pll_divider_q <= pll_divider_q;
      endcase
    end
  end

  // Lock comes from the analog PLL, so it is synchronised; it counts once stages two and three agree
  always @(posedge mclk) begin
    if (sys_rst) begin
      lockS1_q <= 1'b0;
      lockS2_q <= 1'b0;
      lockS3_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      lockS1_q <= pllLockRaw;
      lockS2_q <= lockS1_q;
      lockS3_q <= lockS2_q;
      if (!pllCtl_q[`CDPC_BIT_PLL_EN])
        lock_q <= 1'b0;
      else if (lockS2_q == lockS3_q)
        lock_q <= lockS3_q;
    end
  end

  assign pllCtlRead = {5'h00, pllCtl_q[`CDPC_BIT_EXT_USB], pllCtl_q[`CDPC_BIT_PLL_EN], lock_q};

  // Core cycle: one tick per two oscillator periods in standard mode, every period in double-speed
  assign cpuLast = coreDbl ? 4'h0 : 4'h1;
  always @(posedge mclk) begin
    if (sys_rst) begin
      cpuCnt_q <= 4'h0;
      cpuTick <= 1'b0;
    end else if (cpuCnt_q >= cpuLast) begin
      cpuCnt_q <= 4'h0;
      cpuTick <= 1'b1;
    end else begin
      cpuCnt_q <= cpuCnt_q + 4'h1;
      cpuTick <= 1'b0;
    end
  end

  // Without double-speed every peripheral falls back to 12 periods whatever its select says
  assign perSel[0] = !coreDbl | rateA_q[`CDPC_BIT_TIMER_A];
  assign perSel[1] = !coreDbl | rateA_q[`CDPC_BIT_TIMER_B];
  assign perSel[2] = !coreDbl | rateA_q[`CDPC_BIT_TIMER_C];
  assign perSel[3] = !coreDbl | rateA_q[`CDPC_BIT_UART];
  assign perSel[4] = !coreDbl | rateA_q[`CDPC_BIT_CNT_ARRAY];
  assign perSel[5] = !coreDbl | rateA_q[`CDPC_BIT_WATCHDOG];
  assign perSel[6] = !coreDbl | rateB_q[`CDPC_BIT_SPI];

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : genRate
      cdpc_rate_gen #(.CNT_W(4)) uRate (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .slowSel(perSel[gi]),
        .tickQ(perTick[gi])
      );
    end
  endgenerate

  always @(posedge mclk) begin
    if (sys_rst) begin
      sfrRdata <= 8'h00;
      timerATick <= 1'b0;
      timerBTick <= 1'b0;
      timerCTick <= 1'b0;
      uartTick <= 1'b0;
      counterArrayTick <= 1'b0;
      watchdogTick <= 1'b0;
      spiTick <= 1'b0;
      pllEnable <= 1'b0;
      externalUsbClockSel <= 1'b0;
      oscEnable <= 1'b0;
      pllRefDivider <= 4'h0;
      pllInputDivider <= 4'h0;
      pllLockFlag <= 1'b0;
    end else begin
      sfrRdata <= sfrRe ? regRead(sfrAddr, rateA_q, rateB_q, pllCtlRead, pll_divider_q) : 8'h00;
      timerATick <= perTick[0];
      timerBTick <= perTick[1];
      timerCTick <= perTick[2];
      uartTick <= perTick[3];
      counterArrayTick <= perTick[4];
      watchdogTick <= perTick[5];
      spiTick <= perTick[6];
      pllEnable <= pllCtl_q[`CDPC_BIT_PLL_EN];
      externalUsbClockSel <= pllCtl_q[`CDPC_BIT_EXT_USB];
      oscEnable <= !pllCtl_q[`CDPC_BIT_EXT_USB];
      pllRefDivider <= pll_divider_q[7:4];
      pllInputDivider <= pll_divider_q[3:0];
      pllLockFlag <= lock_q;
    end
  end
endmodule

// File: common/cdpc_regs.vh
// Register offsets, field positions, reset values and cycle counts of the clock control block
`ifndef CDPC_REGS_VH
`define CDPC_REGS_VH
`define CDPC_ADDR_RATE_A 8'h8f
`define CDPC_ADDR_PLL_CTL 8'ha3
`define CDPC_ADDR_PLL_DIV 8'ha4
`define CDPC_ADDR_RATE_B 8'haf
`define CDPC_RST_VAL 8'h00
`define CDPC_RATE_A_MASK 8'h7f
`define CDPC_RATE_B_MASK 8'h01
`define CDPC_PLL_CTL_MASK 8'h06
`define CDPC_BIT_CORE_DBL 0
`define CDPC_BIT_TIMER_A 1
`define CDPC_BIT_TIMER_B 2
`define CDPC_BIT_TIMER_C 3
`define CDPC_BIT_UART 4
`define CDPC_BIT_CNT_ARRAY 5
`define CDPC_BIT_WATCHDOG 6
`define CDPC_BIT_SPI 0
`define CDPC_BIT_EXT_USB 2
`define CDPC_BIT_PLL_EN 1
`define CDPC_BIT_PLL_LOCK 0
`define CDPC_PER_STD 12
`define CDPC_PER_FAST 6
`endif

// File: rtl/cdpc_rate_gen.v
// One rate-enable generator: a pulse every 6 or 12 oscillator periods
module cdpc_rate_gen #(
  parameter CNT_W = 4
) (
  input wire mclk,
  input wire sys_rst,
  input wire slowSel,
  output reg tickQ
);
`include "cdpc_regs.vh"
  localparam [CNT_W-1:0] FAST_LAST = `CDPC_PER_FAST - 1;
  localparam [CNT_W-1:0] STD_LAST = `CDPC_PER_STD - 1;
  reg [CNT_W-1:0] cnt_q;
  wire [CNT_W-1:0] lastVal = slowSel ? STD_LAST : FAST_LAST;
  // A rate change restarts cleanly since the compare uses >=
  always @(posedge mclk) begin
    if (sys_rst) begin
      cnt_q <= {CNT_W{1'b0}};
      tickQ <= 1'b0;
    end else if (cnt_q >= lastVal) begin
      cnt_q <= {CNT_W{1'b0}};
      tickQ <= 1'b1;
    end else begin
      cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      tickQ <= 1'b0;
    end
  end
endmodule

// File: bench/cdpc_clock_ctrl_chk.sv
// Checker on the ports of the clock control block
module cdpc_chk (
  input wire mclk,
  input wire sys_rst,
  input wire [7:0] sfrAddr,
  input wire [7:0] sfrWdata,
  input wire sfrWe,
  input wire sfrRe,
  input wire pllLockRaw,
  input wire [7:0] sfrRdata,
  input wire pllEnable,
  input wire externalUsbClockSel,
  input wire oscEnable,
  input wire [3:0] pllRefDivider,
  input wire [3:0] pllInputDivider,
  input wire pllLockFlag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence sWrCtl; sfrWe && sfrAddr == 8'ha3; endsequence
  // Raw lock is asynchronous, so allow eight cycles of settling
  sequence sLocked; (pllEnable && pllLockRaw) [*8]; endsequence
  sequence sUnlocked; (!pllLockRaw) [*8]; endsequence
  a_lock_needs_en: assert property (!pllEnable |=> !pllLockFlag) else $error("lock flag without enable");
  a_osc_follows_ext: assert property (!$past(sys_rst) |-> oscEnable != externalUsbClockSel) else $error("osc");
  a_ctl_write: assert property (sWrCtl |=> ##1 pllEnable == $past(sfrWdata[1], 2)
    && externalUsbClockSel == $past(sfrWdata[2], 2)) else $error("ctl write");
  a_div_write: assert property (sfrWe && sfrAddr == 8'ha4 |=> ##1
    {pllRefDivider, pllInputDivider} == $past(sfrWdata, 2)) else $error("div write");
  a_lock_sets: assert property (sLocked |-> pllLockFlag) else $error("lock not set");
  a_lock_drops: assert property (sUnlocked |-> !pllLockFlag) else $error("lock not cleared");
  a_rsvd_ctl: assert property (sfrRe && sfrAddr == 8'ha3 |=> sfrRdata[7:3] == 5'h00) else $error("rsvd");
  a_rsvd_rate_b: assert property (sfrRe && sfrAddr == 8'haf |=> sfrRdata[7:1] == 7'h00) else $error("rsvd");
  a_idle_read: assert property (!sfrRe |=> sfrRdata == 8'h00) else $error("idle read data");
endmodule
bind cdpc_clock_ctrl cdpc_chk u_cdpc_chk (.mclk, .sys_rst, .sfrAddr, .sfrWdata, .sfrWe, .sfrRe, .pllLockRaw,
  .sfrRdata, .pllEnable, .externalUsbClockSel, .oscEnable, .pllRefDivider, .pllInputDivider, .pllLockFlag);

// File: bench/tb_top.sv
// Self-checking bench for the clock control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, sys_rst = 1, sfrWe = 0, sfrRe = 0, pllLockRaw = 0;
  logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata;
  logic cpuTick, watchdogTick, counterArrayTick, uartTick, timerCTick, timerBTick, timerATick, spiTick;
  logic pllEnable, externalUsbClockSel, oscEnable, pllLockFlag;
  logic [3:0] pllRefDivider, pllInputDivider;
  int numErrors = 0, checked = 0;
  always #50 mclk = ~mclk;
  cdpc_clock_ctrl u_cdpc_clock_ctrl (.mclk, .sys_rst, .sfrAddr, .sfrWdata, .sfrWe, .sfrRe, .pllLockRaw, .sfrRdata,
    .cpuTick, .watchdogTick, .counterArrayTick, .uartTick, .timerCTick, .timerBTick, .timerATick, .spiTick,
    .pllEnable, .externalUsbClockSel, .oscEnable, .pllRefDivider, .pllInputDivider, .pllLockFlag);
  task closeOut;
    $display("checks %0d mismatches %0d", checked, numErrors);
    if (numErrors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task cmp(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      numErrors++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfrWe = 1;
    sfrAddr = a;
    sfrWdata = d;
    @(negedge mclk);
    sfrWe = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    sfrRe = 1;
    sfrAddr = a;
    @(negedge mclk);
    sfrRe = 0;
    cmp(sfrRdata, e);
  endtask
  // Software side of the lock handshake: poll the flag, bounded
  task pollLock;
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      sfrRe = 1;
      sfrAddr = 8'ha3;
      @(negedge mclk);
      sfrRe = 0;
      n++;
    end while (sfrRdata[0] !== 1'b1 && n < 20);
    if (n >= 20) begin
      numErrors++;
      closeOut;
    end
  endtask
  function logic tk(int s);
    return s == 0 ? cpuTick : (s == 1 ? timerATick : spiTick);
  endfunction
  // Counters free-run, so wait out a rate change before timing the gap
  task gap(input int s, input logic [7:0] e);
    int n;
    n = 0;
    repeat (24) @(negedge mclk);
    while (tk(s) !== 1'b1 && n < 30) begin
      @(negedge mclk);
      n++;
    end
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (tk(s) !== 1'b1 && n < 30);
    if (n >= 30) begin
      numErrors++;
      closeOut;
    end
    cmp(8'(n), e);
  endtask
  task tReset;
    rd(8'h8f, 8'h00);
    rd(8'ha3, 8'h00);
    rd(8'ha4, 8'h00);
    rd(8'haf, 8'h00);
    $display("test reset done");
  endtask
  task tRates;
    gap(0, 8'd2);
    wr(8'h8f, 8'h02);
    gap(1, 8'd12);
    wr(8'h8f, 8'h01);
    gap(0, 8'd1);
    gap(1, 8'd6);
    wr(8'h8f, 8'h03);
    gap(1, 8'd12);
    wr(8'haf, 8'h01);
    gap(2, 8'd12);
    wr(8'haf, 8'h00);
    gap(2, 8'd6);
    $display("test rates done");
  endtask
  task tRsvd;
    wr(8'h8f, 8'h7f);
    rd(8'h8f, 8'h7f);
    wr(8'haf, 8'h01);
    rd(8'haf, 8'h01);
    wr(8'ha3, 8'h06);
    rd(8'ha3, 8'h06);
    rd(8'h90, 8'h00);
    $display("test reserved done");
  endtask
  task tPll;
    wr(8'ha4, 8'hb9);
    rd(8'ha4, 8'hb9);
    cmp({pllRefDivider, pllInputDivider}, 8'hb9);
    wr(8'ha3, 8'h02);
    pllLockRaw = 1;
    pollLock;
    rd(8'ha3, 8'h03);
    cmp({5'h00, externalUsbClockSel, pllEnable, oscEnable}, 8'h03);
    pllLockRaw = 0;
    repeat (10) @(negedge mclk);
    rd(8'ha3, 8'h02);
    pllLockRaw = 1;
    wr(8'ha3, 8'h04);
    repeat (10) @(negedge mclk);
    rd(8'ha3, 8'h04);
    cmp({6'h00, pllLockFlag, oscEnable}, 8'h00);
    sys_rst = 1;
    repeat (2) @(negedge mclk);
    sys_rst = 0;
    rd(8'ha4, 8'h00);
    rd(8'ha3, 8'h00);
    $display("test pll done");
  endtask
  initial begin
    repeat (20) @(negedge mclk);
    sys_rst = 0;
    tReset;
    tRates;
    tRsvd;
    tPll;
    closeOut;
  end
endmodule
